// *** mas_seq.sv ***
// top: conversion/sleep/output sequencer, notch clock selection, power-on reset, mux channel
`timescale 1ns/100ps
// How it works
// (R1) select rising during output aborts transfer and starts a new conversion
// (R2) serial output is high impedance while converter select is high
// (R3) in conversion or sleep, select low shows the not-done status bit
// (R4) output bit changes on each falling edge of the shift clock
// (R5) host samples output bits on shift-clock rising edges
// (R6) notch input high: internal oscillator, first null at 50 Hz
// (R7) notch input low: internal oscillator, first null at 60 Hz
// (R8) clock on notch input becomes conversion clock; null clk/2560, rate clk/20480
// (R9) states run conversion, sleep, output, conversion again
// (R10) sleep lasts while select is high, result held unchanged
// (R11) 4-bit address sampled on mux clock rising edges while mux select high
// (R12) mux select falling applies the last four shifted bits
// (R13) all-zero address keeps the previous channel
// (R14) host loads address only in sleep or at output end
// (R15) select low after sleep shifts out the just-finished result
// (R16) output ends after 32 bits or select high; conversion restarts
// (R17) internal and external shift-clock modes need no configuration
// (R18) offset and full-scale calibration inside every conversion, invisible outside
// (R19) power-on reset pulse of 0.5 ms clears state then starts conversion
// (R20) after power-on reset no channel is enabled; first result invalid
// (R21) host programs a channel at first sleep after power-up
// (R22) word: not-done, zero filler, polarity, range flag, 24-bit result, 4 sub-bits
// (R23) address is enable plus 3-bit channel code; enable zero with a nonzero code turns all off
// (R24) 32nd falling edge drives output high as next not-done flag
// (R25) shift pulses ignored while converter select is high
// (R26) conversion lasts a fixed count of conversion-clock cycles
module mas_seq
   import mas_pkg::*;
#(
   parameter int unsigned POR_LEN = POR_CYCLES
)(
   input  wire logic              clk_sys_in,
   input  wire logic              rst_b_in,
   input  wire logic              shift_clk_in,
   input  wire logic              mux_clk_in,
   input  wire logic              conv_select_n_in,
   input  wire logic              chan_select_n_in,
   input  wire logic              addr_bit_in,
   input  wire logic              notch_select_in,
   input  wire mas_sample_t       sample_in,
   output logic                   serial_result_out,
   output logic                   serial_result_oe_out,
   output mas_chan_t              chan_out,
   output mas_phase_t             phase_out,
   output mas_clk_src_t           clk_src_out,
   output logic                   cal_step_out,
   output logic                   por_busy_out
);
   typedef struct packed {
      logic [1:0]   rst_sync;
      logic [1:0]   conv_sync;
      logic [1:0]   muxsel_sync;
      logic [1:0]   notch_sync;
      logic [1:0]   done_sync;
      logic         done_seen;
      logic         muxsel_q;
      logic         conv_q;
      logic [15:0]  por_cnt;
      logic         por_busy;
      mas_phase_t   phase;
      mas_clk_src_t src;
      logic         notch_q;
      logic [7:0]   edge_win;
      logic [7:0]   osc_cnt;
      logic [14:0]  conv_cnt;
      logic         not_done;
      logic [31:0]  result;
      mas_chan_t    chan;
      logic         cal;
      logic         frame_tgl;
   } mas_top_state_t;

   mas_top_state_t st;
   mas_top_state_t next_st;
   logic           rst_b;
   logic           link_bit;
   logic           link_done_tgl;
   logic [3:0]     link_addr;
   logic           addr_stable_q1;
   logic [3:0]     addr_sync1;
   logic [3:0]     addr_sync2;
   logic           conv_tick;

   assign rst_b = st.rst_sync[1];

   mas_link u_link (
      .shift_clk_in       (shift_clk_in),
      .mux_clk_in         (mux_clk_in),
      .rst_b_in           (rst_b),
      .conv_select_n_in   (conv_select_n_in),
      .chan_select_n_in   (chan_select_n_in),
      .addr_bit_in        (addr_bit_in),
      .result_word_in     (st.result),
      .out_phase_in       (st.phase == MAS_OUTPUT),
      .frame_tgl_in       (st.frame_tgl),
      .not_done_in        (st.not_done),
      .result_bit_out     (link_bit),
      .words_done_tgl_out (link_done_tgl),
      .addr_shift_out     (link_addr)
   );

   // address word is static while mux select is low, so a two-stage copy is safe to read then
   always_ff @(posedge clk_sys_in or negedge rst_b) begin
      if (!rst_b) begin
         addr_sync1 <= ADDR_EMPTY;
         addr_sync2 <= ADDR_EMPTY;
         addr_stable_q1 <= 1'b0;
      end else begin
         addr_sync1 <= link_addr;
         addr_sync2 <= addr_sync1;
         addr_stable_q1 <= 1'b1;
      end
   end

   // conversion-clock tick: internal oscillator division or an external clock edge
   always_comb begin
      conv_tick = 1'b0;
      case (st.src)
         MAS_CLK_EXT: conv_tick = st.notch_sync[1] && !st.notch_q;   // (R8)
         MAS_CLK_OSC50: conv_tick = (st.osc_cnt == 8'(OSC_DIV_50HZ - 1)); // (R6)
         default: conv_tick = (st.osc_cnt == 8'(OSC_DIV_60HZ - 1));  // (R7)
      endcase
   end

   always_comb begin
      next_st = st;
      next_st.rst_sync    = {st.rst_sync[0], 1'b1};
      next_st.conv_sync   = {st.conv_sync[0], conv_select_n_in};
      next_st.muxsel_sync = {st.muxsel_sync[0], chan_select_n_in};
      next_st.notch_sync  = {st.notch_sync[0], notch_select_in};
      next_st.done_sync   = {st.done_sync[0], link_done_tgl};
      next_st.done_seen   = st.done_sync[1];
      next_st.muxsel_q    = st.muxsel_sync[1];
      next_st.conv_q      = st.conv_sync[1];
      next_st.notch_q     = st.notch_sync[1];

      // a notch input that toggles within the window is an external clock; a steady level picks 50/60
      if (st.notch_sync[1] != st.notch_q) begin
         next_st.edge_win = 8'(NOTCH_EDGE_WIN);
         next_st.src      = MAS_CLK_EXT;                             // (R8)
      end else if (st.edge_win != 8'h00) begin
         next_st.edge_win = st.edge_win - 8'h01;
      end else begin
         next_st.src = st.notch_sync[1] ? MAS_CLK_OSC50 : MAS_CLK_OSC60; // (R6) (R7)
      end
      next_st.osc_cnt = conv_tick ? 8'h00 : st.osc_cnt + 8'h01;
      if (st.src == MAS_CLK_EXT) begin
         next_st.osc_cnt = 8'h00;
      end

      // mux select falling: apply last four bits unless all zero
      if (st.muxsel_q && !st.muxsel_sync[1] && addr_stable_q1) begin     // (R12)
         if (addr_sync2 != ADDR_EMPTY) begin                              // (R13)
            next_st.chan = mas_chan_t'(addr_sync2);                       // (R23)
         end
      end

      if (st.por_busy) begin
         // phase, conversion count and status held at reset until the power-on pulse ends
         next_st.por_cnt = st.por_cnt + 16'h0001;
         if (st.por_cnt == 16'(POR_LEN - 1)) begin
            next_st.por_busy = 1'b0;                                      // (R19)
            next_st.phase    = MAS_CONVERT;
            next_st.conv_cnt = '0;
            next_st.not_done = 1'b1;
         end
      end else begin
         case (st.phase)
            MAS_CONVERT: begin
               if (conv_tick) begin
                  next_st.conv_cnt = st.conv_cnt + 15'h0001;
               end
               // calibration occupies the tail of the fixed count, so total length is unchanged
               next_st.cal = (st.conv_cnt >= 15'(WORD_RATE_DIV - CAL_DIV)); // (R18)
               if (conv_tick && st.conv_cnt == 15'(WORD_RATE_DIV - 1)) begin // (R26)
                  next_st.not_done = 1'b0;
                  next_st.cal      = 1'b0;
                  next_st.result   = {1'b0, 1'b0, sample_in.polarity_flag,  // (R22)
                                      sample_in.range_exceed_flag, sample_in.magnitude};
                  next_st.phase    = MAS_SLEEP;                            // (R9)
               end
            end
            MAS_SLEEP: begin
               // result register left untouched while select stays high
               if (!st.conv_sync[1]) begin                                 // (R10)
                  next_st.phase = MAS_OUTPUT;                              // (R15)
                  // new frame token: the shift register reloads on its first edge (R17)
                  next_st.frame_tgl = ~st.frame_tgl;
               end
            end
            default: begin
               // abort on select rising, or finish after the full word
               if ((st.conv_sync[1] && !st.conv_q) ||                      // (R1)
                   (st.done_sync[1] != st.done_seen)) begin                // (R16)
                  next_st.phase    = MAS_CONVERT;                          // (R9)
                  next_st.conv_cnt = '0;
                  next_st.not_done = 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st          <= '0;
         st.por_busy <= 1'b1;
         st.phase    <= MAS_CONVERT;
         st.src      <= MAS_CLK_OSC60;
         st.not_done <= 1'b1;
         st.chan     <= '0;                                                // (R20)
      end else begin
         st <= next_st;
      end
   end

   // output pin: released whenever select is high, status bit outside output phase
   assign serial_result_oe_out = !conv_select_n_in;                        // (R2)
   assign serial_result_out    = conv_select_n_in ? 1'b0 : link_bit;       // (R3)
   assign chan_out             = st.chan;
   assign phase_out            = st.phase;
   assign clk_src_out          = st.src;
   assign cal_step_out         = st.cal;
   assign por_busy_out         = st.por_busy;
endmodule

// *** mas_pkg.sv ***
// shared constants and carrier types for the multiplexed converter sequencer
package mas_pkg;
   localparam int unsigned SYS_CLK_HZ        = 10_000_000;
   localparam real         POR_TIME_MS       = 0.5;
   localparam int unsigned POR_CYCLES        = int'(POR_TIME_MS * SYS_CLK_HZ / 1000.0);
   localparam int unsigned WORD_BITS         = 32;
   localparam int unsigned ADDR_BITS         = 4;
   localparam int unsigned NULL_DIV          = 2560;
   localparam int unsigned WORD_RATE_DIV     = 20480;
   localparam int unsigned CAL_DIV           = 2048;
   localparam int unsigned OSC_DIV_50HZ      = 78;
   localparam int unsigned OSC_DIV_60HZ      = 65;
   localparam int unsigned NOTCH_EDGE_WIN    = 64;
   localparam int unsigned BIT_NOT_DONE      = 31;
   localparam int unsigned BIT_FILLER        = 30;
   localparam int unsigned BIT_POLARITY      = 29;
   localparam int unsigned BIT_RANGE         = 28;
   localparam logic [3:0]  ADDR_EMPTY        = 4'h0;
   localparam logic [2:0]  CHAN_RESET        = 3'h0;
   localparam logic [4:0]  SHIFT_COUNT_RESET = 5'h00;

   typedef enum logic [1:0] {
      MAS_CONVERT,
      MAS_SLEEP,
      MAS_OUTPUT
   } mas_phase_t;

   typedef enum logic [1:0] {
      MAS_CLK_OSC50,
      MAS_CLK_OSC60,
      MAS_CLK_EXT
   } mas_clk_src_t;

   typedef struct packed {
      logic       enable;
      logic [2:0] code;
   } mas_chan_t;

   typedef struct packed {
      logic        polarity_flag;
      logic        range_exceed_flag;
      logic [27:0] magnitude;
   } mas_sample_t;
endpackage

// *** mas_link.sv ***
// link-clock side: output shift register on the shift clock, address shifter on the mux clock
`timescale 1ns/100ps
module mas_link
   import mas_pkg::*;
(
   input  wire logic        shift_clk_in,
   input  wire logic        mux_clk_in,
   input  wire logic        rst_b_in,
   input  wire logic        conv_select_n_in,
   input  wire logic        chan_select_n_in,
   input  wire logic        addr_bit_in,
   input  wire logic [31:0] result_word_in,
   input  wire logic        out_phase_in,
   input  wire logic        frame_tgl_in,
   input  wire logic        not_done_in,
   output logic             result_bit_out,
   output logic             words_done_tgl_out,
   output logic [3:0]       addr_shift_out
);
   typedef struct packed {
      logic [31:0] shreg;
      logic [4:0]  count;
      logic        bit_now;
      logic        done_tgl;
      logic        frame;
   } mas_link_state_t;

   mas_link_state_t st;
   mas_link_state_t next_st;
   logic [3:0]      addr;

   always_comb begin
      next_st = st;
      if (conv_select_n_in || !out_phase_in) begin
         // select high or outside output: shift pulses leave the register untouched
         next_st = st;                                                   // (R25)
      end else begin
         if (st.frame != frame_tgl_in) begin
            // first edge of a new frame: restart from the finished word, even after an abort
            next_st.frame = frame_tgl_in;
            next_st.shreg = result_word_in;
            next_st.count = SHIFT_COUNT_RESET;
         end
         next_st.shreg   = {next_st.shreg[30:0], 1'b1};                  // (R4)
         next_st.bit_now = next_st.shreg[31];
         if (next_st.count == 5'd31) begin
            // 32nd falling edge: line goes high as the next not-done flag
            next_st.bit_now  = 1'b1;                                     // (R24)
            next_st.done_tgl = ~st.done_tgl;                             // (R16)
         end
         next_st.count = next_st.count + 5'd1;
      end
   end

   // only shift-clock edges matter, so either shift-clock mode works with no mode setting (R17)
   always_ff @(negedge shift_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // address is sampled on mux clock rising edges only while mux select is high
   always_ff @(posedge mux_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         addr <= ADDR_EMPTY;
      end else if (chan_select_n_in) begin
         addr <= {addr[2:0], addr_bit_in};                               // (R11)
      end
   end

   // before the first falling edge of a frame the pin shows the live not-done bit, which is bit 31
   assign result_bit_out     = (out_phase_in && !conv_select_n_in && st.frame == frame_tgl_in) ?
                               st.bit_now : not_done_in;
   assign words_done_tgl_out = st.done_tgl;
   assign addr_shift_out     = addr;
endmodule

// *** mas_seq_sva.sv ***
// concurrent checks on the converter sequencer top ports
`timescale 1ns/100ps
module mas_seq_sva
   import mas_pkg::*;
(
   input  wire logic       clk_sys_in,
   input  wire logic       rst_b_in,
   input  wire logic       conv_select_n_in,
   input  wire logic       chan_select_n_in,
   input  wire logic       serial_result_out,
   input  wire logic       serial_result_oe_out,
   input  wire mas_chan_t  chan_out,
   input  wire mas_phase_t phase_out,
   input  wire logic       cal_step_out,
   input  wire logic       por_busy_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);
   // selects pass a two-flop synchroniser, so reactions get a few cycles of slack
   property p_release; serial_result_oe_out == !conv_select_n_in && (!conv_select_n_in || !serial_result_out); endproperty
   a_release: assert property (p_release) else $error("pin not released");
   property p_abort; phase_out == MAS_OUTPUT && $rose(conv_select_n_in) |-> ##[1:5] phase_out == MAS_CONVERT; endproperty
   a_abort: assert property (p_abort) else $error("abort missed");
   property p_order; $changed(phase_out) |-> phase_out == ($past(phase_out) == MAS_OUTPUT ? MAS_CONVERT :
      $past(phase_out) == MAS_CONVERT ? MAS_SLEEP : MAS_OUTPUT); endproperty
   a_order: assert property (p_order) else $error("phase order broken");
   property p_sleep_hold; phase_out == MAS_SLEEP && conv_select_n_in && $past(conv_select_n_in) &&
      $past(conv_select_n_in, 2) |=> phase_out == MAS_SLEEP; endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("sleep left while deselected");
   property p_wake; phase_out == MAS_SLEEP && !conv_select_n_in |-> ##[1:4] phase_out == MAS_OUTPUT; endproperty
   a_wake: assert property (p_wake) else $error("output not started");
   property p_status; phase_out == MAS_SLEEP && $past(phase_out) == MAS_SLEEP && !conv_select_n_in &&
      !$past(conv_select_n_in) |-> !serial_result_out; endproperty
   a_status: assert property (p_status) else $error("sleep status not low");
   property p_chan; $changed(chan_out) |-> !chan_select_n_in && ($past(chan_select_n_in, 2) ||
      $past(chan_select_n_in, 3) || $past(chan_select_n_in, 4)); endproperty
   a_chan: assert property (p_chan) else $error("channel changed without select fall");
   property p_por; por_busy_out || $fell(por_busy_out) |-> phase_out == MAS_CONVERT && chan_out == 4'h0; endproperty
   a_por: assert property (p_por) else $error("power-on state wrong");
   property p_cal; cal_step_out |-> phase_out == MAS_CONVERT && !por_busy_out; endproperty
   a_cal: assert property (p_cal) else $error("calibration outside conversion");
endmodule

// *** mas_host_model.sv ***
// host serial master model: loads channel addresses and reads result words
`timescale 1ns/100ps
module mas_host_model (
   input  wire logic   clk_sys_in,
   input  wire logic   serial_result_in,
   output logic        shift_clk_out     = 1'h0,
   output logic        mux_clk_out       = 1'h0,
   output logic        conv_select_n_out = 1'h1,
   output logic        chan_select_n_out = 1'h0,
   output logic        addr_bit_out      = 1'h0,
   output logic [31:0] word_out          = 32'h0000_0000,
   output logic        word_tgl_out      = 1'h0
);
   // link clocks run in bursts, 6 ns period, read_word also pulses 5 shifts with select high; each bit is taken just before a rising edge
   task automatic pulse_shift(input int n);
      repeat (n) begin
         #3 word_out = {word_out[30:0], serial_result_in};
         shift_clk_out = 1'h1;
         #3 shift_clk_out = 1'h0;
      end
   endtask
   task automatic load_addr(input logic [5:0] bits);
      chan_select_n_out = 1'h1;
      for (int i = 5; i >= 0; i--) begin
         addr_bit_out = bits[i];
         #3 mux_clk_out = 1'h1;
         #3 mux_clk_out = 1'h0;
      end
      // address must outlast the select synchroniser
      repeat (3) @(posedge clk_sys_in);
      #1 chan_select_n_out = 1'h0;
      addr_bit_out = ~addr_bit_out;
   endtask
   task automatic read_word(input int n);
      pulse_shift(5);
      conv_select_n_out = 1'h0;
      repeat (6) @(posedge clk_sys_in);
      #1 pulse_shift(n);
      if (n == 32) word_tgl_out = ~word_tgl_out;
   endtask
endmodule

// *** mas_seq_tb_top.sv ***
// self-checking bench for the converter sequencer against a host model
`timescale 1ns/100ps
module mas_seq_tb_top
   import mas_pkg::*;
;
   logic         clk_sys_in = 1'h0, rst_b_in = 1'h0, notch_select_in = 1'h1, notch_run = 1'h0;
   logic         shift_clk_in, mux_clk_in, conv_select_n_in, chan_select_n_in, addr_bit_in, word_tgl;
   logic         serial_result_out, serial_result_oe_out, cal_step_out;
   logic [31:0]  word, exp_q[$];
   logic [5:0]   addr;
   mas_sample_t  sample_in = '0;
   mas_chan_t    chan_out;
   mas_phase_t   phase_out;
   mas_clk_src_t clk_src_out;
   int           err_total = 0, samples_checked = 0, cycles = 0, conv_ticks = 0, cal_ticks = 0;
   mas_seq #(.POR_LEN(20)) i_dut (.clk_sys_in, .rst_b_in, .shift_clk_in, .mux_clk_in, .conv_select_n_in,
      .chan_select_n_in, .addr_bit_in, .notch_select_in, .sample_in, .serial_result_out, .serial_result_oe_out,
      .chan_out, .phase_out, .clk_src_out, .cal_step_out, .por_busy_out());
   mas_host_model i_host (.clk_sys_in, .serial_result_in(serial_result_out), .shift_clk_out(shift_clk_in),
      .mux_clk_out(mux_clk_in), .conv_select_n_out(conv_select_n_in), .chan_select_n_out(chan_select_n_in),
      .addr_bit_out(addr_bit_in), .word_out(word), .word_tgl_out(word_tgl));
   initial begin
      forever #50 clk_sys_in = ~clk_sys_in;
   end
   always @(posedge clk_sys_in) begin
      cycles++;
      if (notch_run) notch_select_in <= #1 ~notch_select_in;
      if (notch_run && !notch_select_in && phase_out == MAS_CONVERT) conv_ticks++;
      if (notch_run && !notch_select_in && cal_step_out === 1'b1) cal_ticks++;
      if (cycles == 100000) begin
         err_total++;
         conclude();
      end
   end
   initial begin
      forever begin
         @(word_tgl);
         if (exp_q.size() > 0) check("result word", word, exp_q.pop_front());
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic wait_phase(input mas_phase_t p, input int lim, input string what);
      for (int n = 0; n < lim && phase_out !== p; n++) tick(1);
      check(what, phase_out, p);
   endtask
   task automatic conclude();
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      void'($urandom(6));
      sample_in = mas_sample_t'(30'($urandom));
      tick(20);
      rst_b_in = 1'h1;
      check("reset channel", chan_out, 4'h0);
      for (int i = 0; i < 3; i++) begin
         notch_select_in = (i == 0);
         notch_run = (i == 2);
         tick(100);
         check("clock source", clk_src_out, mas_clk_src_t'(i));
      end
      $display("clock source test done");
      wait_phase(MAS_SLEEP, 60000, "first sleep");
      addr = {2'($urandom), 1'h1, 3'($urandom)};
      i_host.load_addr(addr);
      tick(6);
      check("channel load", chan_out, addr[3:0]);
      i_host.load_addr(6'h20);
      tick(6);
      check("zero address", chan_out, addr[3:0]);
      exp_q.push_back({2'h0, sample_in});
      i_host.read_word(32);
      #1 check("pin after last bit", serial_result_out, 1'h1);
      wait_phase(MAS_CONVERT, 6, "after full word");
      conv_ticks = 0;
      cal_ticks = 0;
      tick(2);
      check("busy status", serial_result_out, 1'h1);
      i_host.conv_select_n_out = 1'h1;
      tick(1);
      check("pin released", {serial_result_oe_out, serial_result_out}, 2'h0);
      $display("read test done");
      wait_phase(MAS_SLEEP, 60000, "second sleep");
      check("conversion ticks", 32'(conv_ticks > WORD_RATE_DIV - 8 && conv_ticks < WORD_RATE_DIV + 8), 1'h1);
      check("calibration ticks", 32'(cal_ticks > CAL_DIV - 8 && cal_ticks < CAL_DIV + 8), 1'h1);
      i_host.read_word(5);
      i_host.conv_select_n_out = 1'h1;
      wait_phase(MAS_CONVERT, 6, "aborted read");
      $display("abort test done");
      conclude();
   end
endmodule
bind mas_seq mas_seq_sva i_sva (.clk_sys_in, .rst_b_in, .conv_select_n_in, .chan_select_n_in, .serial_result_out,
   .serial_result_oe_out, .chan_out, .phase_out, .cal_step_out, .por_busy_out);
